// ### swr_consts.svh
`ifndef SWR_CONSTS_SVH
`define SWR_CONSTS_SVH

// timing figures in their own units
`define SWR_CLK_PERIOD_NS 8
`define SWR_MS_NS 1000000
`define SWR_MS_CYCLES (`SWR_MS_NS / `SWR_CLK_PERIOD_NS)
`define SWR_WD_SHORT_MS 100
`define SWR_WD_LONG_MS 1600
`define SWR_RST_ACTIVE_MS 50
`define SWR_CAP_TICKS 1000

// register offsets (byte addresses)
`define SWR_ADDR_W 8
`define SWR_OFS_STATUS 8'h00
`define SWR_OFS_CLEAR 8'h04
`define SWR_OFS_ENABLE 8'h08
`define SWR_OFS_STATE 8'h0C

// event bit positions, shared by status, clear and enable
`define SWR_EV_W 4
`define SWR_EV_WDOG 0
`define SWR_EV_PROX 1
`define SWR_EV_LOWLINE 2
`define SWR_EV_EARLY 3

// state register field positions
`define SWR_ST_RESET_N 0
`define SWR_ST_EARLY_N 1
`define SWR_ST_BACKUP 2
`define SWR_ST_WD_EN 3
`define SWR_ST_FSM_LO 4

// reset values
`define SWR_RST_STATUS 4'h0
`define SWR_RST_ENABLE 4'h0

`endif

// ### swr_pkg.sv
package swr_pkg;

  // pin levels after the two-flop synchroniser
  typedef struct packed {
    logic kick;
    logic kick_float;
    logic tb_sel;
    logic tb_strap;
    logic line_ok;
    logic early_ok;
    logic backup_near;
    logic main_present;
    logic main_above;
  } swr_pins_s;

  typedef enum logic [1:0] {
    SWR_HOLD,
    SWR_STRETCH,
    SWR_RUN
  } swr_rst_e;

endpackage : swr_pkg

// ### swr_proc_model.sv
module swr_proc_model #(
  parameter int KICK_GAP = 7
) (
  input wire logic core_clk,
  input wire logic kick_en,
  output logic watchdog_kick_in,
  output logic chip_enable_in_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_r = 0;
  initial watchdog_kick_in = 1'b0;
  initial chip_enable_in_n = 1'b1;
  always @(posedge core_clk) begin
    cnt_r <= (cnt_r == KICK_GAP - 1) ? 0 : cnt_r + 1;
    // kick well inside the shortest timeout
    if (kick_en && cnt_r == 0) begin
      watchdog_kick_in <= !watchdog_kick_in;
    end
    // ram selects keep moving so gating is seen both ways
    chip_enable_in_n <= cnt_r[1];
  end
endmodule : swr_proc_model

// ### swr_top.sv
// Contract
// - floating kick input disables the watchdog, no watchdog resets.
// - timebase select low: timeout counted from external capacitor ticks.
// - timebase select high: watchdog runs from internal oscillator.
// - internal timebase: strap picks 100 ms or 1.6 s timeout.
// - no kick within timeout: issue a reset pulse.
// - reset low while low line sensed, held 50 ms after recovery.
// - early fail flag low while early sense below reference.
// - backup supply near main supply: issue a reset pulse.
// - switched supply on main while present, else on backup.
// - backup indicator low while main above backup, high otherwise.
// - line good: chip enable out follows chip enable in combinationally.
// - line low: chip enable out forced high.
// - backup mode: kick input ignored entirely.
// - backup mode: early comparison off, early flag held low.
//
// Implementation choices: the address map and the plain strobed port.
`include "swr_consts.svh"

module swr_top
  import swr_pkg::*;
#(
  parameter int MS_CYCLES = `SWR_MS_CYCLES,
  parameter int WD_SHORT_MS = `SWR_WD_SHORT_MS,
  parameter int WD_LONG_MS = `SWR_WD_LONG_MS,
  parameter int RST_ACTIVE_MS = `SWR_RST_ACTIVE_MS,
  parameter int CAP_TICKS = `SWR_CAP_TICKS
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [`SWR_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic watchdog_kick_in,
  input wire logic watchdog_kick_float,
  input wire logic timebase_select,
  input wire logic timebase_strap_pin,
  input wire logic low_line_sense,
  input wire logic early_fail_sense,
  input wire logic backup_supply_near_main,
  input wire logic main_supply_present,
  input wire logic main_above_backup,
  input wire logic chip_enable_in_n,
  output logic chip_enable_out_n,
  output logic reset_n,
  output logic early_fail_flag_n,
  output logic backup_active,
  output logic supply_from_backup,
  output logic irq
);

  localparam int DIV_W = $clog2(MS_CYCLES + 1);
  localparam int WD_W = 16;
  localparam int RC_W = 8;

  // ---------------- pin synchroniser
  swr_pins_s pin_meta_r;
  swr_pins_s pins;
  swr_pins_s prev_r;
  swr_pins_s pin_raw;

  always_comb begin
    pin_raw.kick = watchdog_kick_in;
    pin_raw.kick_float = watchdog_kick_float;
    pin_raw.tb_sel = timebase_select;
    pin_raw.tb_strap = timebase_strap_pin;
    pin_raw.line_ok = low_line_sense;
    pin_raw.early_ok = early_fail_sense;
    pin_raw.backup_near = backup_supply_near_main;
    pin_raw.main_present = main_supply_present;
    pin_raw.main_above = main_above_backup;
  end

  // first stage feeds only the second; prev_r gives edge detection
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_meta_r <= '0;
      pins <= '0;
      prev_r <= '0;
    end else begin
      pin_meta_r <= pin_raw;
      pins <= pin_meta_r;
      prev_r <= pins;
    end
  end

  // ---------------- derived conditions
  logic backup_mode;
  logic kick_edge;
  logic cap_tick;
  logic prox_rise;
  logic line_low;
  logic early_fall;
  logic line_fall;

  always_comb begin
    backup_mode = ~pins.main_present;
    kick_edge = (pins.kick ^ prev_r.kick) & ~backup_mode;
    // capacitor oscillator edges arrive on the strap pin
    cap_tick = pins.tb_strap & ~prev_r.tb_strap;
    prox_rise = pins.backup_near & ~prev_r.backup_near
      & ~backup_mode;
    // backup mode counts as low line: reset held and ram gated
    line_low = ~pins.line_ok | backup_mode;
    early_fall = ~pins.early_ok & prev_r.early_ok & ~backup_mode;
    line_fall = ~pins.line_ok & prev_r.line_ok;
  end

  // ---------------- state
  swr_rst_e state_r, state_nxt;
  logic [DIV_W-1:0] div_r, div_nxt;
  logic [WD_W-1:0] wd_cnt_r, wd_cnt_nxt;
  logic [RC_W-1:0] rst_cnt_r, rst_cnt_nxt;
  logic ms_tick;
  logic wd_en;
  logic wd_tick;
  logic [WD_W-1:0] wd_limit;
  logic wd_timeout;
  logic restart;
  logic div_clr;

  always_comb begin
    ms_tick = (div_r == DIV_W'(MS_CYCLES - 1));
    wd_en = ~pins.kick_float & ~backup_mode
      & (state_r == SWR_RUN);
    if (pins.tb_sel) begin
      wd_tick = ms_tick;
      wd_limit = pins.tb_strap ? WD_W'(WD_LONG_MS)
        : WD_W'(WD_SHORT_MS);
    end else begin
      wd_tick = cap_tick;
      wd_limit = WD_W'(CAP_TICKS);
    end
    wd_timeout = wd_en & ~kick_edge & wd_tick
      & (wd_cnt_r + WD_W'(1) >= wd_limit);
    restart = wd_timeout | prox_rise;

    // watchdog count
    if (!wd_en || kick_edge || wd_timeout) begin
      wd_cnt_nxt = '0;
    end else if (wd_tick) begin
      wd_cnt_nxt = wd_cnt_r + WD_W'(1);
    end else begin
      wd_cnt_nxt = wd_cnt_r;
    end

    // reset sequencer
    state_nxt = state_r;
    rst_cnt_nxt = rst_cnt_r;
    if (line_low) begin
      state_nxt = SWR_HOLD;
      rst_cnt_nxt = '0;
    end else begin
      unique case (state_r)
        SWR_HOLD: begin
          state_nxt = SWR_STRETCH;
          rst_cnt_nxt = '0;
        end
        SWR_STRETCH: begin
          if (prox_rise) begin
            rst_cnt_nxt = '0;
          end else if (ms_tick) begin
            if (rst_cnt_r == RC_W'(RST_ACTIVE_MS - 1)) begin
              state_nxt = SWR_RUN;
            end else begin
              rst_cnt_nxt = rst_cnt_r + RC_W'(1);
            end
          end
        end
        SWR_RUN: begin
          if (restart) begin
            state_nxt = SWR_STRETCH;
            rst_cnt_nxt = '0;
          end
        end
        default: begin
          state_nxt = SWR_HOLD;
          rst_cnt_nxt = '0;
        end
      endcase
    end

    // the millisecond divider restarts with each period so that a
    // stretch or a timeout lasts whole milliseconds, not fewer;
    // kicks realign it only while the watchdog runs, so a processor
    // that keeps kicking cannot stall the reset stretch
    div_clr = ms_tick || (kick_edge && wd_en) || state_nxt != state_r
      || (state_r == SWR_STRETCH && prox_rise);
    if (div_clr) begin
      div_nxt = '0;
    end else begin
      div_nxt = div_r + DIV_W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r <= SWR_HOLD;
      div_r <= '0;
      wd_cnt_r <= '0;
      rst_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      div_r <= div_nxt;
      wd_cnt_r <= wd_cnt_nxt;
      rst_cnt_r <= rst_cnt_nxt;
    end
  end

  // ---------------- supply and flag outputs
  logic reset_n_nxt;
  logic early_nxt;
  logic backup_nxt;
  logic from_backup_nxt;

  always_comb begin
    // registered so the pin never glitches while the sequencer moves
    reset_n_nxt = (state_nxt == SWR_RUN) & ~line_low;
    // comparator is off in backup mode and the flag sits low
    early_nxt = pins.early_ok & ~backup_mode;
    backup_nxt = ~pins.main_above;
    from_backup_nxt = ~pins.main_present;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      reset_n <= 1'b0;
      early_fail_flag_n <= 1'b0;
      backup_active <= 1'b0;
      supply_from_backup <= 1'b0;
    end else begin
      reset_n <= reset_n_nxt;
      early_fail_flag_n <= early_nxt;
      backup_active <= backup_nxt;
      supply_from_backup <= from_backup_nxt;
    end
  end

  // gating stays combinational for speed; the line level behind it
  // is synchronised, so gating lags the pin by two cycles
  assign chip_enable_out_n = (pins.line_ok & ~backup_mode)
    ? chip_enable_in_n : 1'b1;

  // ---------------- registers and interrupt
  logic [`SWR_EV_W-1:0] status_r, status_nxt;
  logic [`SWR_EV_W-1:0] enable_r, enable_nxt;
  logic [`SWR_EV_W-1:0] ev_set;
  logic [`SWR_EV_W-1:0] ev_clr;
  logic [31:0] rdata_nxt;

  always_comb begin
    ev_set = '0;
    ev_set[`SWR_EV_WDOG] = wd_timeout;
    ev_set[`SWR_EV_PROX] = prox_rise;
    ev_set[`SWR_EV_LOWLINE] = line_fall;
    ev_set[`SWR_EV_EARLY] = early_fall;
    ev_clr = '0;
    if (reg_wr && reg_addr == `SWR_OFS_CLEAR) begin
      ev_clr = reg_wdata[`SWR_EV_W-1:0];
    end
    // a new event wins over a clear in the same cycle
    status_nxt = (status_r & ~ev_clr) | ev_set;
    enable_nxt = enable_r;
    if (reg_wr && reg_addr == `SWR_OFS_ENABLE) begin
      enable_nxt = reg_wdata[`SWR_EV_W-1:0];
    end
    rdata_nxt = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        `SWR_OFS_STATUS: rdata_nxt[`SWR_EV_W-1:0] = status_r;
        `SWR_OFS_ENABLE: rdata_nxt[`SWR_EV_W-1:0] = enable_r;
        `SWR_OFS_STATE: begin
          rdata_nxt[`SWR_ST_RESET_N] = reset_n;
          rdata_nxt[`SWR_ST_EARLY_N] = early_fail_flag_n;
          rdata_nxt[`SWR_ST_BACKUP] = backup_active;
          rdata_nxt[`SWR_ST_WD_EN] = wd_en;
          rdata_nxt[`SWR_ST_FSM_LO +: 2] = state_r;
        end
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      status_r <= `SWR_RST_STATUS;
      enable_r <= `SWR_RST_ENABLE;
      reg_rdata <= '0;
    end else begin
      status_r <= status_nxt;
      enable_r <= enable_nxt;
      reg_rdata <= rdata_nxt;
    end
  end

  // and-or of flops only, so the level never glitches
  assign irq = |(status_r & enable_r);

endmodule : swr_top

// ### swr_top_properties.sv
`include "swr_consts.svh"

module swr_top_properties #(
  parameter int MS_CYCLES = `SWR_MS_CYCLES,
  parameter int RST_ACTIVE_MS = `SWR_RST_ACTIVE_MS
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic low_line_sense,
  input wire logic early_fail_sense,
  input wire logic main_supply_present,
  input wire logic main_above_backup,
  input wire logic chip_enable_in_n,
  input wire logic chip_enable_out_n,
  input wire logic reset_n,
  input wire logic early_fail_flag_n,
  input wire logic backup_active,
  input wire logic supply_from_backup
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (reset);
  // low cycles so far, so a short stretch is caught at the rising edge
  int low_r = 0;
  always_ff @(posedge core_clk) begin
    low_r <= reset_n ? 0 : low_r + 1;
  end
  a_ce_follow: assert property (
    (low_line_sense && main_supply_present)[*4] |->
    chip_enable_out_n == chip_enable_in_n) else $error("ce not passed");
  a_ce_block: assert property (
    (!low_line_sense)[*3] |-> chip_enable_out_n) else $error("ce not held");
  a_line_reset: assert property (
    (!low_line_sense)[*5] |-> !reset_n) else $error("no reset on low line");
  a_reset_width: assert property (
    $rose(reset_n) |-> low_r >= RST_ACTIVE_MS * MS_CYCLES)
    else $error("reset pulse too short");
  a_early_low: assert property (
    (!early_fail_sense)[*5] |-> !early_fail_flag_n) else $error("flag high");
  a_early_high: assert property (
    (early_fail_sense && main_supply_present)[*5] |-> early_fail_flag_n)
    else $error("flag low");
  a_backup_mode: assert property (
    (!main_supply_present)[*4] |-> supply_from_backup && !early_fail_flag_n)
    else $error("backup mode outputs wrong");
  a_main_path: assert property (
    main_supply_present[*4] |-> !supply_from_backup)
    else $error("supply not on main");
  a_backup_ind: assert property (
    $stable(main_above_backup)[*5] |-> backup_active == !main_above_backup)
    else $error("backup indicator wrong");
endmodule : swr_top_properties

bind swr_top swr_top_properties #(
  .MS_CYCLES(MS_CYCLES),
  .RST_ACTIVE_MS(RST_ACTIVE_MS)
) swr_top_properties_i (
  .core_clk, .reset, .low_line_sense, .early_fail_sense,
  .main_supply_present, .main_above_backup, .chip_enable_in_n,
  .chip_enable_out_n, .reset_n, .early_fail_flag_n, .backup_active,
  .supply_from_backup
);

// ### swr_top_tb.sv
module swr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RST_C = 30;
  logic core_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, kick_en = 1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic watchdog_kick_float = 0, timebase_select = 1;
  logic timebase_strap_pin = 0, low_line_sense = 1, early_fail_sense = 1;
  logic backup_supply_near_main = 0, main_supply_present = 1;
  logic main_above_backup = 1, watchdog_kick_in, chip_enable_in_n;
  logic chip_enable_out_n, reset_n, early_fail_flag_n, backup_active;
  logic supply_from_backup, irq;
  int failures = 0, checks = 0, cyc = 0, n;
  swr_top #(.MS_CYCLES(10), .RST_ACTIVE_MS(3), .WD_SHORT_MS(4),
    .WD_LONG_MS(8), .CAP_TICKS(5)) swr_top_i (
    .core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .watchdog_kick_in, .watchdog_kick_float, .timebase_select,
    .timebase_strap_pin, .low_line_sense, .early_fail_sense,
    .backup_supply_near_main, .main_supply_present, .main_above_backup,
    .chip_enable_in_n, .chip_enable_out_n, .reset_n, .early_fail_flag_n,
    .backup_active, .supply_from_backup, .irq);
  swr_proc_model swr_proc_model_i (.core_clk, .kick_en, .watchdog_kick_in,
    .chip_enable_in_n);
  initial forever #4 core_clk = ~core_clk;
  task automatic finish_test();
    if (failures == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  // the run needs some 1000 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 8000) begin
      failures++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1;
    @(posedge core_clk);
    reg_wr <= 0;
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge core_clk);
    reg_rd <= 0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask : bus_rd
  task automatic wait_rst(input logic lvl);
    n = 0;
    while (reset_n !== lvl && n < 300) begin
      @(negedge core_clk);
      n++;
    end
  endtask : wait_rst
  task automatic tick();
    @(posedge core_clk);
    timebase_strap_pin <= 1;
    repeat (3) @(posedge core_clk);
    timebase_strap_pin <= 0;
    repeat (3) @(posedge core_clk);
  endtask : tick
  task automatic t_regs();
    bus_rd(8'h08);
    chk(d, 32'h0, "enable reset value");
    bus_wr(8'h08, 32'hF);
    bus_rd(8'h08);
    chk(d, 32'hF, "enable readback");
    bus_rd(8'h10);
    chk(d, 32'h0, "unmapped read");
    bus_rd(8'h04);
    chk(d, 32'h0, "clear read");
  endtask : t_regs
  task automatic t_line();
    wait_rst(1);
    @(posedge core_clk);
    low_line_sense <= 0;
    repeat (6) @(negedge core_clk);
    chk(reset_n, 0, "line reset");
    chk(chip_enable_out_n, 1, "ce gate");
    bus_rd(8'h00);
    chk(d & 32'h4, 32'h4, "line status");
    chk(irq, 1, "irq set");
    bus_wr(8'h04, 32'h4);
    @(negedge core_clk);
    chk(irq, 0, "irq clear");
    @(posedge core_clk);
    low_line_sense <= 1;
    wait_rst(1);
    chk(32'(n >= RST_C && n <= RST_C + 8), 1, "stretch");
  endtask : t_line
  task automatic t_wdog(input logic strap, input int lim);
    @(posedge core_clk);
    timebase_strap_pin <= strap;
    repeat (3 * lim) @(negedge core_clk);
    chk(reset_n, 1, "kicked watchdog");
    @(posedge core_clk);
    kick_en <= 0;
    wait_rst(0);
    chk(32'(n + 8 >= lim && n <= lim + 6), 1, "timeout");
    bus_rd(8'h00);
    chk(d & 32'h1, 32'h1, "timeout status");
    wait_rst(1);
    @(posedge core_clk);
    kick_en <= 1;
    bus_wr(8'h04, 32'hF);
  endtask : t_wdog
  task automatic t_cap();
    @(posedge core_clk);
    timebase_select <= 0;
    timebase_strap_pin <= 0;
    repeat (10) @(posedge core_clk);
    kick_en <= 0;
    repeat (4) tick();
    repeat (20) @(negedge core_clk);
    chk(reset_n, 1, "four ticks");
    tick();
    wait_rst(0);
    chk(32'(n < 6), 1, "fifth tick");
    wait_rst(1);
    bus_wr(8'h04, 32'hF);
  endtask : t_cap
  task automatic t_float();
    @(posedge core_clk);
    timebase_select <= 1;
    watchdog_kick_float <= 1;
    repeat (150) @(negedge core_clk);
    chk(reset_n, 1, "float no reset");
    bus_rd(8'h0C);
    chk(d, 32'h23, "state with float");
    @(posedge core_clk);
    watchdog_kick_float <= 0;
    kick_en <= 1;
  endtask : t_float
  task automatic t_prox();
    @(posedge core_clk);
    backup_supply_near_main <= 1;
    repeat (6) @(negedge core_clk);
    chk(reset_n, 0, "prox reset");
    @(posedge core_clk);
    backup_supply_near_main <= 0;
    wait_rst(1);
    chk(32'(n >= RST_C - 8), 1, "prox width");
    bus_rd(8'h00);
    chk(d & 32'h2, 32'h2, "prox status");
    bus_wr(8'h04, 32'hF);
  endtask : t_prox
  task automatic t_supply();
    @(posedge core_clk);
    main_supply_present <= 0;
    main_above_backup <= 0;
    repeat (8) @(negedge core_clk);
    chk(supply_from_backup, 1, "on backup");
    chk(backup_active, 1, "backup on");
    chk(early_fail_flag_n, 0, "flag in backup");
    chk(chip_enable_out_n, 1, "ce in backup");
    @(posedge core_clk);
    main_supply_present <= 1;
    main_above_backup <= 1;
    repeat (8) @(negedge core_clk);
    chk(supply_from_backup, 0, "on main");
    chk(backup_active, 0, "backup off");
    wait_rst(1);
  endtask : t_supply
  task automatic t_early();
    @(posedge core_clk);
    early_fail_sense <= 0;
    repeat (6) @(negedge core_clk);
    chk(early_fail_flag_n, 0, "early low");
    bus_rd(8'h00);
    chk(d & 32'h8, 32'h8, "early status");
    chk(irq, 1, "early irq");
    @(posedge core_clk);
    early_fail_sense <= 1;
    repeat (6) @(negedge core_clk);
    chk(early_fail_flag_n, 1, "early high");
  endtask : t_early
  initial begin
    repeat (20) @(posedge core_clk);
    reset <= 0;
    t_regs();
    t_line();
    t_wdog(0, 40);
    t_wdog(1, 80);
    t_cap();
    t_float();
    t_prox();
    t_supply();
    t_early();
    finish_test();
  end
endmodule : swr_top_tb
